/* verilog/osc_defs.svh */
// register map, field positions and reset values of the oscillator block
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MOR_OFFSET        8'h20
`define MEAS_OFFSET       8'h24
`define IRQ_STATUS_OFFSET 8'h28
`define IRQ_MASK_OFFSET   8'h2C

// ----------------------------------------------------------------
// main oscillator control fields
// ----------------------------------------------------------------
`define MOR_RESET         32'h0000_0008
`define MOR_STORE_MASK    32'h0700_FF7F
`define KEY_MSB           23
`define KEY_LSB           16
`define KEY_VALUE         8'h37
`define BIT_SLOW_MON      26
`define BIT_CFD_EN        25
`define BIT_MAIN_SEL      24
`define STARTUP_MSB       15
`define STARTUP_LSB       8
`define RCF_MSB           6
`define RCF_LSB           4
`define BIT_RC_EN         3
`define BIT_WAIT_MODE     2
`define BIT_XT_BYPASS     1
`define BIT_XT_EN         0

// ----------------------------------------------------------------
// measurement register fields
// ----------------------------------------------------------------
`define BIT_MEAS_READY    16
`define BIT_MEAS_RESTART  20
`define BIT_MEAS_SRC      24

// ----------------------------------------------------------------
// interrupt bits and timing counts
// ----------------------------------------------------------------
`define IRQ_WIDTH         2
`define EV_MEAS_DONE      0
`define EV_WRITE_REJECT   1
`define SLOW_PERIODS      16
`define COUNT_WIDTH       16

`endif

/* verilog/osc_pkg.sv */
// types shared by the oscillator control modules
package osc_pkg;

  // measurement sequence, gray coded along idle-arm-count-done
  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'b00,
    MEAS_ARM   = 2'b01,
    MEAS_COUNT = 2'b11,
    MEAS_DONE  = 2'b10
  } meas_state_t;

  typedef logic [31:0] word_t;

endpackage

/* verilog/edge_if.sv */
// carrier for rising-edge pulses of the sampled clock inputs
`timescale 1ns/100ps
interface edge_if #(parameter int N = 3);
  logic [N-1:0] rise;
  modport src (output rise);
  modport dst (input rise);
endinterface

/* verilog/edge_pulse.sv */
// rising-edge detector for slow, synchronously sampled clock inputs
`timescale 1ns/100ps
module edge_pulse #(
  parameter int N = 3
) (
  input  logic         core_clk,
  input  logic         rst,
  input  logic [N-1:0] level,
  edge_if.src          edges
);

  logic [N-1:0] prev;

  // ----------------------------------------------------------------
  // one detector per input
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_det
      // registered one-cycle pulse on each rising level
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          prev[i]       <= 1'b0;
          edges.rise[i] <= 1'b0;
        end else begin
          prev[i]       <= level[i];
          edges.rise[i] <= level[i] & ~prev[i];
        end
      end
    end
  endgenerate

endmodule

/* verilog/irq_status.sv */
// sticky event status with read-to-clear and masked level interrupt
`timescale 1ns/100ps
module irq_status #(
  parameter int W = 2
) (
  input  logic         core_clk,
  input  logic         rst,
  input  logic [W-1:0] event_in,
  input  logic         clear,
  input  logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic         irq
);

  logic [W-1:0] next_status;

  // set beats clear: an event in the clearing cycle survives
  always_comb begin
    next_status = (clear ? {W{1'b0}} : status) | event_in;
  end

  // status flops and registered interrupt level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= {W{1'b0}};
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & mask);
    end
  end

endmodule

/* verilog/main_osc_ctrl_freq_meter.sv */
// main oscillator control register and frequency meter
//
// How it works
// - writes to the control register are dropped while write protection is on
// - a control write needs key 0x37 in bits 23:16, else it is aborted
// - bit 26 enables frequency monitoring of the 32.768 kHz crystal
// - bit 25 switches the clock failure detector on or off
// - bit 24 selects main clock, RC oscillator at zero, crystal at one
// - ready reads zero when count invalid, oscillator off, or just restarted
// - ready reads one once oscillator enabled and a finished count exists
// - count holds selected clock cycles within 16 slow clock periods
`timescale 1ns/100ps
`include "osc_defs.svh"
module main_osc_ctrl_freq_meter
  import osc_pkg::*;
#(
  parameter int COUNT_W      = `COUNT_WIDTH,
  parameter int SLOW_PERIODS = `SLOW_PERIODS
) (
  input  logic        core_clk,
  input  logic        rst,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_write,
  input  logic        reg_read,
  output logic [31:0] reg_rdata,
  input  logic        write_protect_enable,
  input  logic        slow_clock,
  input  logic        rc_osc_clk,
  input  logic        xtal_osc_clk,
  output logic        rc_oscillator_enable,
  output logic        xtal_oscillator_enable,
  output logic        xtal_bypass,
  output logic        wait_mode,
  output logic [2:0]  rc_freq_select,
  output logic [7:0]  xtal_startup_time,
  output logic        main_source_select,
  output logic        clock_failure_detect_en,
  output logic        slow_crystal_freq_monitor_en,
  output logic        irq
);

  localparam int SW = (SLOW_PERIODS > 1) ? $clog2(SLOW_PERIODS) : 1;
  localparam logic [SW-1:0] LAST_PERIOD = SW'(SLOW_PERIODS - 1);
  localparam logic [COUNT_W-1:0] COUNT_MAX = {COUNT_W{1'b1}};

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count
      $error("count width must lie between 1 and 16");
    end
    if (SLOW_PERIODS < 1 || SLOW_PERIODS > 256) begin : g_bad_periods
      $error("slow period count must lie between 1 and 256");
    end
  endgenerate

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // true when the access hits the given offset
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0]          mor;          // stored control fields
  logic                 meas_src;     // counter source select
  logic [`IRQ_WIDTH-1:0] irq_mask;
  logic [`IRQ_WIDTH-1:0] irq_stat;
  logic [`IRQ_WIDTH-1:0] irq_events;
  meas_state_t          state;
  logic [SW-1:0]        slow_cnt;
  logic [COUNT_W-1:0]   run_cnt;
  logic [COUNT_W-1:0]   count;
  logic                 ready;
  logic                 osc_on_q;
  logic                 done_pulse;
  logic                 reject_pulse;

  // ----------------------------------------------------------------
  // access qualifiers
  // ----------------------------------------------------------------
  logic mor_wr;
  logic key_ok;
  logic mor_accept;
  logic meas_wr;
  logic mask_wr;
  logic stat_rd;
  logic restart_req;
  logic osc_on;
  logic start;
  logic sel_rise;
  logic slow_rise;

  edge_if #(.N(3)) edges ();

  assign mor_wr  = reg_write & hit(reg_addr, `MOR_OFFSET);
  assign meas_wr = reg_write & hit(reg_addr, `MEAS_OFFSET);
  assign mask_wr = reg_write & hit(reg_addr, `IRQ_MASK_OFFSET);
  assign stat_rd = reg_read  & hit(reg_addr, `IRQ_STATUS_OFFSET);

  assign key_ok = (reg_wdata[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);

  assign mor_accept = mor_wr & key_ok & ~write_protect_enable;

  assign restart_req = meas_wr & reg_wdata[`BIT_MEAS_RESTART];

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // reset value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mor <= `MOR_RESET;
    end else if (mor_accept) begin
      // key is never stored, it reads back as zero
      mor <= reg_wdata & `MOR_STORE_MASK;
    end
  end

  // rejected writes raise an event for software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reject_pulse <= 1'b0;
    end else begin
      reject_pulse <= mor_wr & ~mor_accept;
    end
  end

  // ----------------------------------------------------------------
  // oscillator control outputs
  // ----------------------------------------------------------------
  // slow crystal monitor enable
  assign slow_crystal_freq_monitor_en = mor[`BIT_SLOW_MON];
  assign clock_failure_detect_en = mor[`BIT_CFD_EN];
  assign main_source_select = mor[`BIT_MAIN_SEL];

  assign rc_oscillator_enable   = mor[`BIT_RC_EN];
  assign xtal_oscillator_enable = mor[`BIT_XT_EN];
  assign xtal_bypass            = mor[`BIT_XT_BYPASS];
  assign wait_mode              = mor[`BIT_WAIT_MODE];
  assign rc_freq_select         = mor[`RCF_MSB:`RCF_LSB];
  assign xtal_startup_time      = mor[`STARTUP_MSB:`STARTUP_LSB];

  // ----------------------------------------------------------------
  // measurement and mask registers
  // ----------------------------------------------------------------
  // source of the counted clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meas_src <= 1'b0;
    end else if (meas_wr) begin
      meas_src <= reg_wdata[`BIT_MEAS_SRC];
    end
  end

  // interrupt mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (mask_wr) begin
      irq_mask <= reg_wdata[`IRQ_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // edge detection of the sampled clocks
  // ----------------------------------------------------------------
  edge_pulse #(.N(3)) u_edges (
    .core_clk (core_clk),
    .rst      (rst),
    .level    ({xtal_osc_clk, rc_osc_clk, slow_clock}),
    .edges    (edges.src)
  );

  assign slow_rise = edges.rise[0];
  assign sel_rise  = meas_src ? edges.rise[2] : edges.rise[1];

  // measured oscillator is running when its enable is set
  assign osc_on = meas_src ? mor[`BIT_XT_EN] : mor[`BIT_RC_EN];

  // a restart or a fresh enable starts a new measurement
  assign start = osc_on & (restart_req | ~osc_on_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_on_q <= 1'b0;
    end else begin
      osc_on_q <= osc_on;
    end
  end

  // ----------------------------------------------------------------
  // measurement sequence
  // ----------------------------------------------------------------
  // window of slow periods
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= MEAS_IDLE;
      slow_cnt <= '0;
    end else if (!osc_on) begin
      state    <= MEAS_IDLE;
      slow_cnt <= '0;
    end else if (start) begin
      state    <= MEAS_ARM;
      slow_cnt <= '0;
    end else begin
      case (state)
        MEAS_ARM: begin
          // window opens on a slow edge
          if (slow_rise) begin
            state <= MEAS_COUNT;
          end
        end
        MEAS_COUNT: begin
          if (slow_rise) begin
            if (slow_cnt == LAST_PERIOD) begin
              state <= MEAS_DONE;
            end else begin
              slow_cnt <= slow_cnt + 1'b1;
            end
          end
        end
        MEAS_DONE: begin
          state <= MEAS_DONE;
        end
        default: begin
          state <= MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_cnt <= '0;
    end else if (state != MEAS_COUNT || start) begin
      run_cnt <= '0;
    end else if (sel_rise && run_cnt != COUNT_MAX) begin
      run_cnt <= run_cnt + 1'b1;
    end
  end

  // completion of the window
  logic window_end;
  assign window_end = osc_on & ~start & (state == MEAS_COUNT) &
                      slow_rise & (slow_cnt == LAST_PERIOD);

  // count held stable until the next completion
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (window_end) begin
      if (sel_rise && run_cnt != COUNT_MAX) begin
        count <= run_cnt + 1'b1;
      end else begin
        count <= run_cnt;
      end
    end
  end

  // ready cleared on restart or disable
  // ready set on a finished count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else if (!osc_on || start) begin
      ready <= 1'b0;
    end else if (window_end) begin
      ready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_pulse <= 1'b0;
    end else begin
      done_pulse <= window_end;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    irq_events = '0;
    irq_events[`EV_MEAS_DONE]    = done_pulse;
    irq_events[`EV_WRITE_REJECT] = reject_pulse;
  end

  irq_status #(.W(`IRQ_WIDTH)) u_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .event_in (irq_events),
    .clear    (stat_rd),
    .mask     (irq_mask),
    .status   (irq_stat),
    .irq      (irq)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  word_t next_rdata;

  // read data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        `MOR_OFFSET: begin
          next_rdata = mor;
        end
        `MEAS_OFFSET: begin
          next_rdata[COUNT_W-1:0]      = count;
          next_rdata[`BIT_MEAS_READY] = ready;
          next_rdata[`BIT_MEAS_SRC]   = meas_src;
        end
        `IRQ_STATUS_OFFSET: begin
          next_rdata[`IRQ_WIDTH-1:0] = irq_stat;
        end
        `IRQ_MASK_OFFSET: begin
          next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

/* verification/osc_meter_chk_chk.sv */
// port-level assertions for the oscillator control block
`timescale 1ns/100ps
module osc_meter_chk #(
  parameter int COUNT_W      = 16,
  parameter int SLOW_PERIODS = 16
) (
  input logic        core_clk,
  input logic        rst,
  input logic [7:0]  reg_addr,
  input logic [31:0] reg_wdata,
  input logic        reg_write,
  input logic        reg_read,
  input logic [31:0] reg_rdata,
  input logic        write_protect_enable,
  input logic        rc_oscillator_enable,
  input logic        xtal_oscillator_enable,
  input logic        main_source_select,
  input logic        clock_failure_detect_en,
  input logic        slow_crystal_freq_monitor_en,
  input logic        irq
);
  // helper decode of control writes
  logic       ctrl_wr;
  logic       key_ok;
  logic       osc_on;
  logic [3:0] ctl;
  assign ctrl_wr = reg_write && (reg_addr == 8'h20);
  assign key_ok  = (reg_wdata[23:16] == 8'h37) && !write_protect_enable;
  assign osc_on  = rc_oscillator_enable | xtal_oscillator_enable;
  assign ctl     = {slow_crystal_freq_monitor_en, clock_failure_detect_en,
                    main_source_select, rc_oscillator_enable};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_RESET_VALUE: assert property ($fell(rst) |-> ctl == 4'h1 &&
    !xtal_oscillator_enable && !irq) else $error("bad reset value");
  AST_PROTECT_HOLD: assert property (ctrl_wr && write_protect_enable
    |=> $stable(ctl) && $stable(xtal_oscillator_enable))
    else $error("protected write changed control");
  AST_KEY_ABORT: assert property (ctrl_wr && reg_wdata[23:16] != 8'h37
    |=> $stable(ctl)) else $error("bad key write changed control");
  AST_MON_LOAD: assert property (ctrl_wr && key_ok
    |=> slow_crystal_freq_monitor_en == $past(reg_wdata[26]))
    else $error("monitor enable not loaded");
  AST_CFD_LOAD: assert property (ctrl_wr && key_ok
    |=> clock_failure_detect_en == $past(reg_wdata[25]))
    else $error("failure detect enable not loaded");
  AST_SEL_LOAD: assert property (ctrl_wr && key_ok
    |=> main_source_select == $past(reg_wdata[24]))
    else $error("source select not loaded");
  AST_RESTART_CLEARS: assert property (reg_write && reg_addr == 8'h24
    && reg_wdata[20] ##1 reg_read && reg_addr == 8'h24 |=> !reg_rdata[16])
    else $error("ready set right after restart");
  AST_READY_NEEDS_OSC: assert property (reg_read && reg_addr == 8'h24
    && !osc_on && !$past(osc_on) && !$past(osc_on, 2) |=> !reg_rdata[16])
    else $error("ready set with oscillators off");

  // main scenarios reached
  cover property (ctrl_wr && key_ok);
  cover property (reg_read && reg_addr == 8'h24 ##1 reg_rdata[16]);
  cover property ($rose(irq));
endmodule

bind main_osc_ctrl_freq_meter osc_meter_chk #(
  .COUNT_W(COUNT_W),
  .SLOW_PERIODS(SLOW_PERIODS)
) osc_meter_chk_i (
  .core_clk(core_clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .write_protect_enable(write_protect_enable),
  .rc_oscillator_enable(rc_oscillator_enable),
  .xtal_oscillator_enable(xtal_oscillator_enable),
  .main_source_select(main_source_select),
  .clock_failure_detect_en(clock_failure_detect_en),
  .slow_crystal_freq_monitor_en(slow_crystal_freq_monitor_en),
  .irq(irq)
);

/* verification/testbench.sv */
// self-checking bench for the oscillator control and frequency meter
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  localparam int SLOW_N = 4;
  logic        core_clk, rst, reg_write, reg_read, write_protect_enable;
  logic        slow_clock, rc_osc_clk, xtal_osc_clk, irq;
  logic [7:0]  reg_addr, cyc, stt;
  logic [2:0]  rcf;
  logic        wm, byp;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic        rc_en, xt_en, main_sel, cfd_en, mon_en;
  int          mismatches, num_checks;

  main_osc_ctrl_freq_meter #(.SLOW_PERIODS(SLOW_N))
    main_osc_ctrl_freq_meter_i (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .write_protect_enable(write_protect_enable),
    .slow_clock(slow_clock), .rc_osc_clk(rc_osc_clk),
    .xtal_osc_clk(xtal_osc_clk), .rc_oscillator_enable(rc_en),
    .xtal_oscillator_enable(xt_en), .xtal_bypass(byp), .wait_mode(wm),
    .rc_freq_select(rcf), .xtal_startup_time(stt),
    .main_source_select(main_sel),
    .clock_failure_detect_en(cfd_en), .slow_crystal_freq_monitor_en(mon_en),
    .irq(irq));

  // 40 MHz core clock
  always #12.5 core_clk = ~core_clk;
  // slow clock 16 cycles, rc 2 cycles, crystal 4 cycles, no shared rising edges
  always @(posedge core_clk) begin
    if (rst) begin
      cyc <= 8'h00;
      {slow_clock, rc_osc_clk, xtal_osc_clk} <= 3'b000;
    end else begin
      cyc          <= cyc + 8'h01;
      slow_clock   <= cyc[3];
      rc_osc_clk   <= cyc[0];
      xtal_osc_clk <= cyc[1];
    end
  end

  // ------------------------------------------------------------
  // bus tasks, entered right after a rising edge
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_read  <= 1'b0;
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    reg_addr  <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(posedge core_clk);
    rd_val = reg_rdata;
  endtask
  task automatic idle(input int n);
    reg_write <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    rd(8'h24);
    while (rd_val[16] !== 1'b1 && n < 400) begin
      rd(8'h24);
      n++;
    end
    `CHK(rd_val[16], 1'b1)
    // count taken from a second read
    rd(8'h24);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h20);
    `CHK(rd_val, 32'h0000_0008)
    `CHK({rc_en, xt_en, main_sel, cfd_en, mon_en, irq}, 6'h20)
    `CHK({stt, rcf, wm, byp}, 13'h0000)
  endtask
  task automatic t_fields;
    logic [31:0] v;
    for (int i = 24; i <= 26; i++) begin
      v = 32'h0037_5AFE | (32'h1 << i);
      wr(8'h20, v);
      idle(1);
      `CHK(mon_en, 1'(i == 26))
      `CHK(cfd_en, 1'(i == 25))
      `CHK(main_sel, 1'(i == 24))
      `CHK({stt, rcf, wm, byp}, {8'h5A, 3'h7, 2'b11})
      rd(8'h20);
      `CHK(rd_val, v & 32'h0700_FF7F)
    end
    wr(8'h20, 32'h0037_0008);
    idle(1);
  endtask
  task automatic t_refuse;
    wr(8'h2C, 32'h0000_0002);
    wr(8'h20, 32'h0136_000B);
    idle(4);
    `CHK({main_sel, xt_en, irq}, 3'b001)
    rd(8'h28);
    `CHK(rd_val[1], 1'b1)
    idle(2);
    `CHK(irq, 1'b0)
    wr(8'h2C, 32'h0000_0000);
    write_protect_enable <= 1'b1;
    wr(8'h20, 32'h0737_000B);
    idle(4);
    write_protect_enable <= 1'b0;
    `CHK({mon_en, cfd_en, main_sel, xt_en, irq}, 5'h00)
    rd(8'h28);
    `CHK(rd_val[1], 1'b1)
    rd(8'h28);
    `CHK(rd_val[1], 1'b0)
    wr(8'h40, 32'h0137_0000);
    rd(8'h40);
    `CHK(rd_val, 32'h0)
    rd(8'h20);
    `CHK(rd_val, 32'h0000_0008)
  endtask
  task automatic t_measure;
    wr(8'h24, 32'h0010_0000);
    rd(8'h24);
    `CHK(rd_val[16], 1'b0)
    wait_ready();
    `CHK(rd_val[15:0], 16'(SLOW_N * 8))
    rd(8'h28);
    `CHK(rd_val[0], 1'b1)
    wr(8'h20, 32'h0037_0009);
    wr(8'h24, 32'h0110_0000);
    wait_ready();
    `CHK(rd_val[15:0], 16'(SLOW_N * 4))
    wr(8'h20, 32'h0037_0000);
    idle(4);
    rd(8'h24);
    `CHK(rd_val[16], 1'b0)
  endtask
  task automatic t_rereset;
    wr(8'h20, 32'h0737_FFFF);
    idle(1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK({rc_en, xt_en, main_sel, cfd_en, mon_en, irq}, 6'h20)
    `CHK({stt, rcf, wm, byp}, 13'h0000)
    rd(8'h20);
    `CHK(rd_val, 32'h0000_0008)
  endtask

  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {reg_write, reg_read, write_protect_enable} = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_fields();
    t_refuse();
    t_measure();
    t_rereset();
    report_and_stop();
  end
endmodule
